// ==== design/ddr_term_pkg.sv ====
// Shared constants, types and helpers for the termination link
package ddr_term_pkg;
   localparam int MR_W = 13;
   localparam int LAT_W = 6;
   localparam int HIST_W = 16;
   localparam logic [LAT_W-1:0] LAT_OFFSET = 6'h02;
   localparam logic [LAT_W-1:0] TERM_MIN_HIGH_SHORT = 6'h04;
   localparam logic [LAT_W-1:0] TERM_MIN_HIGH_LONG = 6'h06;
   localparam logic [LAT_W-1:0] SKEW_ONE = 6'h01;
   localparam logic [LAT_W-1:0] MODE_UPDATE_DELAY = 6'h0c;
   localparam int NOM_B0 = 2;
   localparam int NOM_B1 = 6;
   localparam int NOM_B2 = 9;
   localparam int LEVEL_BIT = 7;
   localparam int DLL_DIS_BIT = 0;
   localparam int WR_LO = 9;
   localparam int WR_HI = 10;
   localparam int REF_OHM = 240;
   localparam logic [3:0] DIV_OFF = 4'h0;
   localparam logic [3:0] DIV_2 = 4'h2;
   localparam logic [3:0] DIV_4 = 4'h4;
   localparam logic [3:0] DIV_6 = 4'h6;
   localparam logic [3:0] DIV_8 = 4'h8;
   localparam logic [3:0] DIV_12 = 4'hc;
   localparam int CLK_PS = 4000;
   localparam int ASYNC_MIN_PS = 2000;
   localparam int ASYNC_MAX_PS = 8500;
   localparam int ASYNC_MIN_CYC = (ASYNC_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam int ASYNC_MAX_CYC = ASYNC_MAX_PS / CLK_PS;
   localparam int CK_PERIOD_PS = 80000;
   localparam logic [4:0] CK_HALF_CYC = 5'(CK_PERIOD_PS / (2 * CLK_PS));

   typedef enum logic [1:0] {
      CMD_NOP = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_MODE1 = 2'b10,
      CMD_MODE2 = 2'b11
   } cmd_t;

   function automatic logic [2:0] nom_code(input logic [MR_W-1:0] mr);
      return {mr[NOM_B2], mr[NOM_B1], mr[NOM_B0]};
   endfunction

   function automatic logic [3:0] nom_div(input logic [2:0] code);
      unique case (code)
         3'h1: return DIV_4;
         3'h2: return DIV_2;
         3'h3: return DIV_6;
         3'h4: return DIV_12;
         3'h5: return DIV_8;
         default: return DIV_OFF;
      endcase
   endfunction

   function automatic logic nom_write_ok(input logic [3:0] d);
      return d == DIV_2 || d == DIV_4 || d == DIV_6;
   endfunction

   function automatic logic [LAT_W-1:0] lat_of(input logic [3:0] wl,
                                              input logic [3:0] al);
      logic [LAT_W-1:0] t;
      t = LAT_W'(wl) + LAT_W'(al) - LAT_OFFSET;
      if (t == '0) t = SKEW_ONE;
      if (t > LAT_W'(HIST_W)) t = LAT_W'(HIST_W);
      return t;
   endfunction
endpackage

// ==== design/ddr_term_if.sv ====
// Link between memory controller and termination logic
`timescale 1ns/10ps
`default_nettype none
interface ddr_term_if;
   import ddr_term_pkg::*;
   logic ck;
   logic odt;
   cmd_t cmd;
   logic chop;
   logic [MR_W-1:0] mr;
   modport ctrl (output ck, output odt, output cmd, output chop,
                 output mr);
   modport dram (input ck, input odt, input cmd, input chop, input mr);
endinterface
`default_nettype wire

// ==== design/ddr_term_dram.sv ====
// Memory-side termination control: nominal, write and leveling states
`timescale 1ns/10ps
`default_nettype none
module ddr_term_dram
   import ddr_term_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   ddr_term_if.dram link,
   input wire logic [3:0] write_latency,
   input wire logic [3:0] additive_latency,
   input wire logic dll_pd_off,
   input wire logic dll_syncing,
   input wire logic self_refresh,
   output logic [3:0] dq_div,
   output logic [3:0] dqs_div,
   output logic write_term_active,
   output logic term_settling,
   output logic code_illegal,
   output logic write_misuse
);
   typedef struct packed {
      logic [2:0] ck_s;
      logic [2:0] odt_s;
      logic [2:0] chop_s;
      logic [1:0] cmd_s1;
      logic [1:0] cmd_s2;
      logic [1:0] cmd_s3;
      logic [MR_W-1:0] mr_s1;
      logic [MR_W-1:0] mr_s2;
      logic [MR_W-1:0] mr_s3;
      logic ck_st;
      logic odt_st;
      logic chop_st;
      logic [1:0] cmd_st;
      logic [MR_W-1:0] mr_st;
      logic [MR_W-1:0] mr1;
      logic [MR_W-1:0] mr2;
      logic [HIST_W-1:0] hist;
      logic pend;
      logic sync_on;
      logic [ASYNC_MIN_CYC-1:0] async_odt;
      logic wr_run;
      logic wr_chop;
      logic wr_on;
      logic [LAT_W-1:0] wr_cnt;
      logic [LAT_W:0] mod_cnt;
      logic [3:0] dq_div;
      logic [3:0] dqs_div;
      logic illegal;
      logic misuse;
   } dram_state_t;

   dram_state_t state_ff;
   dram_state_t nxt_state;

   always_comb begin
      logic rise;
      logic fall;
      logic async_mode;
      logic nom_on;
      logic dyn;
      logic [LAT_W-1:0] lat;
      logic [LAT_W-1:0] ret;
      logic [LAT_W-1:0] cnt;
      logic [3:0] idx;
      logic [3:0] nd;
      logic [3:0] wd;
      rise = 1'b0;
      fall = 1'b0;
      async_mode = 1'b0;
      nom_on = 1'b0;
      dyn = 1'b0;
      lat = '0;
      ret = '0;
      cnt = '0;
      idx = '0;
      nd = DIV_OFF;
      wd = DIV_OFF;
      nxt_state = state_ff;

      // Three-stage pin sampling, value taken when stages 2 and 3 agree
      nxt_state.ck_s = {state_ff.ck_s[1:0], link.ck};
      nxt_state.odt_s = {state_ff.odt_s[1:0], link.odt};
      nxt_state.chop_s = {state_ff.chop_s[1:0], link.chop};
      nxt_state.cmd_s1 = link.cmd;
      nxt_state.cmd_s2 = state_ff.cmd_s1;
      nxt_state.cmd_s3 = state_ff.cmd_s2;
      nxt_state.mr_s1 = link.mr;
      nxt_state.mr_s2 = state_ff.mr_s1;
      nxt_state.mr_s3 = state_ff.mr_s2;
      if (state_ff.ck_s[1] == state_ff.ck_s[2]) begin
         nxt_state.ck_st = state_ff.ck_s[2];
      end
      if (state_ff.odt_s[1] == state_ff.odt_s[2]) begin
         nxt_state.odt_st = state_ff.odt_s[2];
      end
      if (state_ff.chop_s[1] == state_ff.chop_s[2]) begin
         nxt_state.chop_st = state_ff.chop_s[2];
      end
      if (state_ff.cmd_s2 == state_ff.cmd_s3) begin
         nxt_state.cmd_st = state_ff.cmd_s3;
      end
      if (state_ff.mr_s2 == state_ff.mr_s3) begin
         nxt_state.mr_st = state_ff.mr_s3;
      end
      rise = nxt_state.ck_st & ~state_ff.ck_st;
      fall = ~nxt_state.ck_st & state_ff.ck_st;

      lat = lat_of(write_latency, additive_latency);
      idx = 4'(lat - SKEW_ONE);
      dyn = state_ff.mr2[WR_LO] | state_ff.mr2[WR_HI];
      ret = lat + (state_ff.wr_chop ? TERM_MIN_HIGH_SHORT
                                    : TERM_MIN_HIGH_LONG);

      if (rise) begin
         nxt_state.hist = {state_ff.hist[HIST_W-2:0], state_ff.odt_st};
         // Enable registered lat edges ago takes effect now
         nxt_state.pend = state_ff.hist[idx];
         if (state_ff.hist[idx]) begin
            nxt_state.sync_on = 1'b1;
         end
         if (state_ff.mod_cnt != '0) begin
            nxt_state.mod_cnt = state_ff.mod_cnt - 1'b1;
         end
         if (state_ff.wr_run) begin
            cnt = state_ff.wr_cnt + 1'b1;
            nxt_state.wr_cnt = cnt;
            if (cnt == lat) begin
               nxt_state.wr_on = dyn;
            end
            if (cnt == ret) begin
               nxt_state.wr_on = 1'b0;
               nxt_state.wr_run = 1'b0;
            end
         end
         unique case (cmd_t'(state_ff.cmd_st))
            CMD_WRITE: begin
               // New write restarts the burst window
               nxt_state.wr_run = 1'b1;
               nxt_state.wr_cnt = '0;
               nxt_state.wr_chop = state_ff.chop_st;
            end
            CMD_MODE1: begin
               nxt_state.mr1 = state_ff.mr_st;
               nxt_state.mod_cnt = (LAT_W+1)'(lat) +
                  (LAT_W+1)'(MODE_UPDATE_DELAY) +
                  (LAT_W+1)'(SKEW_ONE) + (LAT_W+1)'(SKEW_ONE);
            end
            CMD_MODE2: begin
               nxt_state.mr2 = state_ff.mr_st;
               nxt_state.mod_cnt = (LAT_W+1)'(lat) +
                  (LAT_W+1)'(MODE_UPDATE_DELAY) +
                  (LAT_W+1)'(SKEW_ONE) + (LAT_W+1)'(SKEW_ONE);
            end
            CMD_NOP: begin
            end
         endcase
      end
      // Turn-off lands on the half cycle after the latency edge
      if (fall && !state_ff.pend) begin
         nxt_state.sync_on = 1'b0;
      end

      nxt_state.async_odt = state_ff.odt_st;
      async_mode = dll_pd_off | dll_syncing;
      nom_on = async_mode ? state_ff.async_odt[0] : state_ff.sync_on;

      nd = nom_div(nom_code(state_ff.mr1));
      wd = state_ff.mr2[WR_HI] ? (state_ff.mr2[WR_LO] ? DIV_OFF : DIV_2)
                               : (state_ff.mr2[WR_LO] ? DIV_4 : DIV_OFF);
      if (state_ff.mr1[DLL_DIS_BIT] || self_refresh) begin
         nxt_state.dq_div = DIV_OFF;
         nxt_state.dqs_div = DIV_OFF;
      end else if (state_ff.mr1[LEVEL_BIT]) begin
         nxt_state.dq_div = DIV_OFF;
         nxt_state.dqs_div = nom_on ? nd : DIV_OFF;
      end else if (state_ff.wr_on && dyn) begin
         // Tied-high enable with nominal off still gives write cover
         nxt_state.dq_div = wd;
         nxt_state.dqs_div = wd;
      end else if (nom_on) begin
         nxt_state.dq_div = nd;
         nxt_state.dqs_div = nd;
      end else begin
         nxt_state.dq_div = DIV_OFF;
         nxt_state.dqs_div = DIV_OFF;
      end
      nxt_state.illegal = nom_code(state_ff.mr1) > 3'h5;
      nxt_state.misuse = ~dyn & state_ff.wr_run & nom_on &
                         ~nom_write_ok(nd);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign dq_div = state_ff.dq_div;
   assign dqs_div = state_ff.dqs_div;
   assign write_term_active = state_ff.wr_on;
   assign term_settling = state_ff.mod_cnt != '0;
   assign code_illegal = state_ff.illegal;
   assign write_misuse = state_ff.misuse;
endmodule
`default_nettype wire

// ==== design/ddr_term_ctrl.sv ====
// Controller-side driver of memory clock, enable pin and commands
`timescale 1ns/10ps
`default_nettype none
module ddr_term_ctrl
   import ddr_term_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   ddr_term_if.ctrl link,
   input wire logic [3:0] write_latency,
   input wire logic [3:0] additive_latency,
   input wire logic cmd_valid,
   input wire cmd_t cmd_kind,
   input wire logic cmd_chop,
   input wire logic [MR_W-1:0] cmd_data,
   output logic cmd_ready,
   output logic cmd_reject,
   input wire logic odt_req,
   input wire logic odt_with_write,
   input wire logic tied_high,
   input wire logic init_done,
   input wire logic read_busy,
   input wire logic self_refresh
);
   typedef struct packed {
      logic [4:0] div;
      logic ck;
      logic odt;
      logic [1:0] cmd;
      logic chop;
      logic [MR_W-1:0] mr;
      logic pend;
      logic [1:0] p_kind;
      logic p_chop;
      logic [MR_W-1:0] p_data;
      logic [LAT_W-1:0] hold;
      logic [LAT_W:0] settle;
      logic [MR_W-1:0] sh_mr1;
      logic [MR_W-1:0] sh_mr2;
      logic reject;
   } ctrl_state_t;

   ctrl_state_t state_ff;
   ctrl_state_t nxt_state;

   always_comb begin
      logic fall;
      logic bad;
      logic wr;
      logic want;
      logic dyn;
      logic [LAT_W-1:0] lat;
      logic [LAT_W-1:0] h;
      fall = 1'b0;
      bad = 1'b0;
      wr = 1'b0;
      want = 1'b0;
      dyn = 1'b0;
      h = '0;
      lat = lat_of(write_latency, additive_latency);
      nxt_state = state_ff;
      nxt_state.reject = 1'b0;
      dyn = state_ff.sh_mr2[WR_LO] | state_ff.sh_mr2[WR_HI];

      // Clock divider drives the memory clock
      if (state_ff.div == CK_HALF_CYC - 1'b1) begin
         nxt_state.div = '0;
         nxt_state.ck = ~state_ff.ck;
         fall = state_ff.ck;
      end else begin
         nxt_state.div = state_ff.div + 1'b1;
      end

      if (cmd_valid && cmd_ready) begin
         unique case (cmd_kind)
            CMD_MODE1: begin
               bad = nom_code(cmd_data) > 3'h5;
               // Leveling toggles only together with the nominal field
               if (cmd_data[LEVEL_BIT] && nom_code(cmd_data) == 3'h0) begin
                  bad = 1'b1;
               end
               if (!cmd_data[LEVEL_BIT] && state_ff.sh_mr1[LEVEL_BIT] &&
                   nom_code(cmd_data) != 3'h0) begin
                  bad = 1'b1;
               end
            end
            CMD_WRITE: begin
               bad = ~dyn & (odt_req | odt_with_write) &
                     nom_code(state_ff.sh_mr1) != 3'h0 &
                     ~nom_write_ok(nom_div(nom_code(state_ff.sh_mr1)));
            end
            default: begin
               bad = 1'b0;
            end
         endcase
         nxt_state.reject = bad;
         if (!bad) begin
            nxt_state.pend = 1'b1;
            nxt_state.p_kind = cmd_kind;
            nxt_state.p_chop = cmd_chop;
            nxt_state.p_data = cmd_data;
         end
      end

      // Commands and enable change on the falling edge only
      if (fall) begin
         nxt_state.cmd = CMD_NOP;
         if (state_ff.settle != '0) begin
            nxt_state.settle = state_ff.settle - 1'b1;
         end
         if (state_ff.hold != '0) begin
            nxt_state.hold = state_ff.hold - 1'b1;
         end
         if (state_ff.pend) begin
            nxt_state.pend = 1'b0;
            nxt_state.cmd = state_ff.p_kind;
            nxt_state.chop = state_ff.p_chop;
            nxt_state.mr = state_ff.p_data;
            wr = cmd_t'(state_ff.p_kind) == CMD_WRITE;
            if (cmd_t'(state_ff.p_kind) == CMD_MODE1) begin
               nxt_state.sh_mr1 = state_ff.p_data;
            end
            if (cmd_t'(state_ff.p_kind) == CMD_MODE2) begin
               nxt_state.sh_mr2 = state_ff.p_data;
            end
            if (!wr) begin
               nxt_state.settle = (LAT_W+1)'(lat) +
                  (LAT_W+1)'(MODE_UPDATE_DELAY) +
                  (LAT_W+1)'(SKEW_ONE) + (LAT_W+1)'(SKEW_ONE);
            end
         end
         want = (odt_req | (wr & odt_with_write) | state_ff.hold != '0) &
                init_done & ~read_busy & ~self_refresh &
                ~state_ff.sh_mr1[DLL_DIS_BIT];
         want = want | tied_high;
         nxt_state.odt = want;
         if (want && !state_ff.odt) begin
            nxt_state.hold = TERM_MIN_HIGH_SHORT - SKEW_ONE;
         end
         if (want && wr) begin
            h = (state_ff.p_chop ? TERM_MIN_HIGH_SHORT
                                 : TERM_MIN_HIGH_LONG) - SKEW_ONE;
            if (h > nxt_state.hold) begin
               nxt_state.hold = h;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign cmd_ready = ~state_ff.pend & (state_ff.settle == '0);
   assign cmd_reject = state_ff.reject;
   assign link.ck = state_ff.ck;
   assign link.odt = state_ff.odt;
   assign link.cmd = cmd_t'(state_ff.cmd);
   assign link.chop = state_ff.chop;
   assign link.mr = state_ff.mr;
endmodule
`default_nettype wire

// ==== bench/ddr_term_sva.sv ====
// Checker on the termination link signals
`timescale 1ns/10ps
`default_nettype none
module ddr_term_sva
   import ddr_term_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ck,
   input wire logic odt,
   input wire cmd_t cmd,
   input wire logic chop,
   input wire logic [MR_W-1:0] mr
);
   logic [4:0] half_ff;
   logic seen_ff;
   logic [3:0] hold_ff;
   logic [3:0] need_ff;
   logic [MR_W-1:0] mr1_ff;
   logic [2:0] code;
   assign code = {mr[NOM_B2], mr[NOM_B1], mr[NOM_B0]};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // Half-period, enable hold and mode-one trackers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         half_ff <= '0;
         seen_ff <= 1'b0;
         hold_ff <= '0;
         need_ff <= 4'h4;
         mr1_ff <= '0;
      end else begin
         half_ff <= $changed(ck) ? 5'h00 : half_ff + 5'h01;
         if ($changed(ck))
            seen_ff <= 1'b1;
         if ($changed(cmd) && cmd == CMD_WRITE && odt) begin
            hold_ff <= '0;
            need_ff <= chop ? 4'h4 : 4'h6;
         end else if ($rose(odt)) begin
            hold_ff <= '0;
            need_ff <= 4'h4;
         end else if ($fell(ck) && odt && hold_ff != 4'hf)
            hold_ff <= hold_ff + 4'h1;
         if ($changed(cmd) && cmd == CMD_MODE1)
            mr1_ff <= mr;
      end
   end
   a_ck_half_period: assert property (($changed(ck) && seen_ff) |->
      half_ff == CK_HALF_CYC - 5'h01) else $error("ck half period wrong");
   a_odt_at_fall: assert property ($changed(odt) |-> $fell(ck))
      else $error("odt moved off a ck fall");
   a_cmd_at_fall: assert property ($changed({cmd, chop, mr}) |-> $fell(ck))
      else $error("command moved off a ck fall");
   a_cmd_one_period: assert property (($changed(cmd) && cmd != CMD_NOP) |=>
      $stable(cmd) [*8] ##[1:30] (cmd == CMD_NOP))
      else $error("command not held one ck period");
   a_nom_code_legal: assert property ((cmd == CMD_MODE1) |-> code < 3'h6)
      else $error("reserved nominal code on link");
   a_hold_short_ok: assert property (($fell(odt) && need_ff == 4'h4) |->
      hold_ff >= 4'h3) else $error("odt short hold broken");
   a_hold_long_ok: assert property (($fell(odt) && need_ff == 4'h6) |->
      hold_ff >= 4'h5) else $error("odt long hold broken");
   a_no_odt_dll: assert property ($rose(odt) |-> !mr1_ff[DLL_DIS_BIT])
      else $error("odt raised with dll disabled");
   a_level_entry: assert property (($changed(cmd) && cmd == CMD_MODE1 &&
      mr[LEVEL_BIT]) |-> code != 3'h0)
      else $error("leveling entered without nominal");
   a_level_exit: assert property (($changed(cmd) && cmd == CMD_MODE1 &&
      !mr[LEVEL_BIT] && mr1_ff[LEVEL_BIT]) |-> code == 3'h0)
      else $error("leveling left with nominal on");
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench joining both termination ends
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ddr_term_pkg::*;
   localparam int LAT = 3;
   localparam int CKP = 80;
   logic clock, arst_n, cmd_valid, cmd_chop, cmd_ready, cmd_reject;
   cmd_t cmd_kind;
   logic [MR_W-1:0] cmd_data;
   logic odt_req, odt_with_write, tied_high, init_done, read_busy;
   logic self_refresh, dll_pd_off, dll_syncing;
   logic [3:0] write_latency, additive_latency, dq_div, dqs_div;
   logic write_term_active, term_settling, code_illegal, write_misuse;
   logic [3:0] nom_tab [1:5];
   int n_errors, n_checks;
   ddr_term_if link ();
   ddr_term_ctrl i_ddr_term_ctrl (.clock(clock), .arst_n(arst_n),
      .link(link), .write_latency(write_latency),
      .additive_latency(additive_latency), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .cmd_chop(cmd_chop), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .cmd_reject(cmd_reject), .odt_req(odt_req),
      .odt_with_write(odt_with_write), .tied_high(tied_high),
      .init_done(init_done), .read_busy(read_busy),
      .self_refresh(self_refresh));
   ddr_term_dram i_ddr_term_dram (.clock(clock), .arst_n(arst_n),
      .link(link), .write_latency(write_latency),
      .additive_latency(additive_latency), .dll_pd_off(dll_pd_off),
      .dll_syncing(dll_syncing), .self_refresh(self_refresh),
      .dq_div(dq_div), .dqs_div(dqs_div),
      .write_term_active(write_term_active), .term_settling(term_settling),
      .code_illegal(code_illegal), .write_misuse(write_misuse));
   ddr_term_sva i_ddr_term_sva (.clock(clock), .arst_n(arst_n),
      .ck(link.ck), .odt(link.odt), .cmd(link.cmd), .chop(link.chop),
      .mr(link.mr));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [MR_W-1:0] mode1(input logic [2:0] c,
                                             input logic lv, input logic dd);
      logic [MR_W-1:0] m;
      m = '0;
      m[NOM_B0] = c[0];
      m[NOM_B1] = c[1];
      m[NOM_B2] = c[2];
      m[LEVEL_BIT] = lv;
      m[DLL_DIS_BIT] = dd;
      return m;
   endfunction
   function automatic logic [MR_W-1:0] mode2(input logic [1:0] w);
      logic [MR_W-1:0] m;
      m = '0;
      m[WR_LO] = w[0];
      m[WR_HI] = w[1];
      return m;
   endfunction
   function automatic logic win(input realtime t0, input int lo);
      return ($realtime - t0 >= lo) && ($realtime - t0 < lo + 60);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (n_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_ready();
      int i;
      i = 0;
      #1;
      while (cmd_ready !== 1'b1 && i < 4000) begin
         @(posedge clock);
         #1;
         i++;
      end
      check(i < 4000, 1'b1);
      @(posedge clock);
   endtask
   task automatic send(input cmd_t k, input logic c,
                       input logic [MR_W-1:0] d, input logic rej);
      wait_ready();
      cmd_kind <= k;
      cmd_chop <= c;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1;
      check(cmd_reject, rej);
   endtask
   task automatic edge_chk(input int lo);
      realtime t0;
      logic [3:0] v;
      int i;
      v = dq_div;
      @(link.odt);
      t0 = $realtime;
      i = 0;
      while (dq_div === v && i < 500) begin
         @(posedge clock);
         #1;
         i++;
      end
      check(win(t0, lo), 1'b1);
   endtask
   task automatic wr_chk(input logic c, input logic [3:0] wd,
                         input logic [3:0] nd);
      realtime t0;
      send(CMD_WRITE, c, '0, 1'b0);
      @(link.cmd);
      t0 = $realtime;
      @(posedge write_term_active);
      check(win(t0, 40 + LAT * CKP), 1'b1);
      repeat (3) @(posedge clock);
      #1;
      check(dq_div, wd);
      @(negedge write_term_active);
      check(win(t0, 40 + (LAT + (c ? 4 : 6)) * CKP), 1'b1);
      repeat (3) @(posedge clock);
      #1;
      check(dq_div, nd);
   endtask
   task automatic set_odt(input logic v, input int n);
      @(posedge clock);
      odt_req <= v;
      repeat (n) @(posedge clock);
      #1;
   endtask
   initial begin
      #300000;
      n_errors++;
      end_of_test();
   end
   initial begin
      {arst_n, cmd_valid, cmd_chop, odt_req, odt_with_write} = '0;
      {tied_high, init_done, read_busy, self_refresh} = '0;
      {dll_pd_off, dll_syncing} = '0;
      cmd_kind = CMD_NOP;
      cmd_data = '0;
      write_latency = 4'h5;
      additive_latency = 4'h0;
      n_errors = 0;
      n_checks = 0;
      nom_tab = '{4'h4, 4'h2, 4'h6, 4'hc, 4'h8};
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      init_done <= 1'b1;
      #1;
      check({dq_div, dqs_div, write_term_active, term_settling,
             code_illegal, write_misuse, cmd_ready}, 13'h0001);
      for (int c = 1; c <= 5; c++) begin
         send(CMD_MODE1, 1'b0, mode1(3'(c), 1'b0, 1'b0), 1'b0);
         wait_ready();
         odt_req <= 1'b1;
         edge_chk(40 + LAT * CKP);
         check({dq_div, dqs_div}, {nom_tab[c], nom_tab[c]});
         set_odt(1'b0, 0);
         edge_chk(80 + LAT * CKP);
      end
      send(CMD_MODE1, 1'b0, mode1(3'h6, 1'b0, 1'b0), 1'b1);
      send(CMD_MODE1, 1'b0, mode1(3'h7, 1'b0, 1'b0), 1'b1);
      check(code_illegal, 1'b0);
      send(CMD_MODE2, 1'b0, mode2(2'h0), 1'b0);
      set_odt(1'b1, 0);
      send(CMD_WRITE, 1'b0, '0, 1'b1);
      send(CMD_MODE1, 1'b0, mode1(3'h2, 1'b0, 1'b0), 1'b0);
      send(CMD_WRITE, 1'b0, '0, 1'b0);
      @(link.cmd);
      repeat (110) @(posedge clock);
      #1;
      check({write_term_active, write_misuse, dq_div}, 6'h02);
      send(CMD_MODE1, 1'b0, mode1(3'h3, 1'b0, 1'b0), 1'b0);
      send(CMD_MODE2, 1'b0, mode2(2'h1), 1'b0);
      wr_chk(1'b1, 4'h4, 4'h6);
      send(CMD_MODE2, 1'b0, mode2(2'h2), 1'b0);
      wr_chk(1'b0, 4'h2, 4'h6);
      set_odt(1'b0, 0);
      edge_chk(80 + LAT * CKP);
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         dll_syncing <= (k == 0);
         dll_pd_off <= (k == 1);
         set_odt(1'b1, 0);
         edge_chk(0);
         set_odt(1'b0, 0);
         edge_chk(0);
      end
      @(posedge clock);
      {dll_syncing, dll_pd_off} <= 2'b00;
      read_busy <= 1'b1;
      set_odt(1'b1, 100);
      check(link.odt, 1'b0);
      @(posedge clock);
      read_busy <= 1'b0;
      init_done <= 1'b0;
      repeat (100) @(posedge clock);
      #1;
      check(link.odt, 1'b0);
      @(posedge clock);
      init_done <= 1'b1;
      self_refresh <= 1'b1;
      repeat (100) @(posedge clock);
      #1;
      check({link.odt, dq_div}, 5'h00);
      @(posedge clock);
      self_refresh <= 1'b0;
      odt_req <= 1'b0;
      send(CMD_MODE2, 1'b0, mode2(2'h0), 1'b0);
      send(CMD_MODE1, 1'b0, mode1(3'h0, 1'b1, 1'b0), 1'b1);
      send(CMD_MODE1, 1'b0, mode1(3'h2, 1'b1, 1'b0), 1'b0);
      @(link.cmd);
      set_odt(1'b1, 20);
      check(term_settling, 1'b1);
      wait_ready();
      repeat (100) @(posedge clock);
      #1;
      check({dqs_div, dq_div}, 8'h20);
      send(CMD_MODE1, 1'b0, mode1(3'h2, 1'b0, 1'b0), 1'b1);
      send(CMD_MODE1, 1'b0, mode1(3'h0, 1'b0, 1'b0), 1'b0);
      wait_ready();
      // Device counts its window from the ck rise, half a ck later
      repeat (20) @(posedge clock);
      #1;
      check({dqs_div, dq_div, term_settling}, 9'h000);
      send(CMD_MODE2, 1'b0, mode2(2'h1), 1'b0);
      @(posedge clock);
      odt_req <= 1'b0;
      tied_high <= 1'b1;
      read_busy <= 1'b1;
      repeat (60) @(posedge clock);
      #1;
      check(link.odt, 1'b1);
      wr_chk(1'b0, 4'h4, 4'h0);
      @(posedge clock);
      tied_high <= 1'b0;
      read_busy <= 1'b0;
      repeat (40) @(posedge clock);
      odt_with_write <= 1'b1;
      send(CMD_WRITE, 1'b0, '0, 1'b0);
      @(link.odt);
      repeat (118) @(posedge clock);
      #1;
      check(link.odt, 1'b1);
      repeat (2) @(posedge clock);
      #1;
      check(link.odt, 1'b0);
      @(posedge clock);
      odt_with_write <= 1'b0;
      send(CMD_MODE1, 1'b0, mode1(3'h2, 1'b0, 1'b1), 1'b0);
      wait_ready();
      set_odt(1'b1, 120);
      check({link.odt, dq_div, dqs_div}, 9'h000);
      end_of_test();
   end
endmodule
`default_nettype wire
